/* core/fdds_side_signals.sv */
// Drive-side signal logic of the floppy controller, with its Wishbone register slave
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "fdds_defines.svh"

module fdds_side_signals
	import fdds_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic mini_floppy_clock_halve_n_i,
	input wire logic density_select_n_i,
	input wire logic test_n_i,
	input wire logic ready_i,
	input wire logic protect_tab_in_n_i,
	input wire logic track_zero_in_n_i,
	input wire logic index_n_i,
	input wire logic raw_read_n_i,
	input wire logic head_settled_in_i,
	output logic side_select_out_o,
	output logic inner_track_zone_o,
	output logic write_gate_o,
	output logic write_pulse_out_o,
	output logic head_load_out_o,
	output logic irq_out_o,
	output logic pump_o,
	output logic pump_oe_o
);

	localparam logic [10:0] FM_CELL = 11'(`FDDS_FM_CELL_CYC);
	localparam logic [10:0] MFM_CELL = 11'(`FDDS_MFM_CELL_CYC);
	localparam logic [10:0] PULSE_LEN = 11'(`FDDS_PULSE_CYC);

	// Builds 16 cells, clock then data, MSB first; marks supply their own clock pattern
	function automatic logic [15:0] fdds_cells(input logic [7:0] data, input logic [7:0] clkpat,
			input logic use_pat, input logic prev, input logic mfm);
		logic [15:0] cells;
		logic p;
		logic c;
		cells = 16'h0000;
		p = prev;
		for (int i = 7; i >= 0; i--) begin
			if (use_pat) begin
				c = clkpat[i];
			end else if (mfm) begin
				c = ~(p | data[i]);
			end else begin
				c = 1'b1;
			end
			cells = {cells[13:0], c, data[i]};
			p = data[i];
		end
		return cells;
	endfunction : fdds_cells

	logic ready_s;
	logic protect_n_s;
	logic track0_n_s;
	logic index_n_s;
	logic raw_n_s;
	logic settled_s;
	logic settled_n_s;

	// Drive input sync
	// two-stage sync
	fdds_sync #(
		.WIDTH(6)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i({ready_i, protect_tab_in_n_i, track_zero_in_n_i, index_n_i, raw_read_n_i, ~head_settled_in_i}),
		.sync_o({ready_s, protect_n_s, track0_n_s, index_n_s, raw_n_s, settled_n_s})
	);

	// Settled travels inverted so the all-ones sync reset reads as not engaged
	assign settled_s = ~settled_n_s;

	fdds_state_t state;
	fdds_state_t next_state;
	logic is_write;
	logic next_is_write;
	logic side;
	logic next_side;
	logic [7:0] track;
	logic [7:0] next_track;
	logic irq;
	logic next_irq;
	logic record_not_found;
	logic next_rnf;
	logic wprot;
	logic next_wprot;
	logic lost;
	logic next_lost;
	logic gate;
	logic next_gate;
	logic zone;
	logic next_zone;
	logic pend_v;
	logic next_pend_v;
	logic [7:0] pend_data;
	logic [7:0] next_pend_data;
	logic [7:0] pend_clk;
	logic [7:0] next_pend_clk;
	logic pend_mark;
	logic next_pend_mark;
	logic [1:0] pump_mode;
	logic [1:0] next_pump_mode;
	logic pump_q;
	logic next_pump_q;
	logic pump_oe_q;
	logic next_pump_oe_q;
	logic [15:0] rd_count;
	logic [15:0] next_rd_count;
	logic raw_prev;
	logic next_raw_prev;
	logic ack;
	logic next_ack;
	logic [31:0] dat;
	logic [31:0] next_dat;

	fdds_enc_t enc_st;
	fdds_enc_t next_enc_st;
	logic [15:0] cells;
	logic [15:0] next_cells;
	logic [3:0] cell_idx;
	logic [3:0] next_cell_idx;
	logic [10:0] cell_cnt;
	logic [10:0] next_cell_cnt;
	logic prev_bit;
	logic next_prev_bit;
	logic wpulse;
	logic next_wpulse;
	logic enc_take;
	logic enc_lost;
	logic [10:0] cell_len;
	logic enc_go;

	logic req;
	logic wr;
	logic [7:0] badr;
	fdds_kind_t kind;
	logic [7:0] status;

	assign req = wb_cyc_i & wb_stb_i & ~ack;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign badr = {wb_adr_i[7:2], 2'b00};
	assign kind = fdds_kind_t'(wb_dat_i[`FDDS_CMD_KIND_MSB:0]);
	assign enc_go = (state == FDDS_S_WRITE) & gate;

	always_comb begin
		status = 8'h00;
		status[`FDDS_ST_BUSY] = (state != FDDS_S_IDLE);
		status[`FDDS_ST_DRQ] = (state == FDDS_S_WRITE) & ~pend_v;
		status[`FDDS_ST_LOST] = lost;
		status[`FDDS_ST_TRK0] = ~track0_n_s;
		status[`FDDS_ST_RNF] = record_not_found;
		status[`FDDS_ST_INDEX] = ~index_n_s;
		status[`FDDS_ST_WPROT] = wprot;
		status[`FDDS_ST_NRDY] = ~ready_s;
	end

	always_comb begin
		next_state = state;
		next_is_write = is_write;
		next_side = side;
		next_track = track;
		next_irq = irq;
		next_rnf = record_not_found;
		next_wprot = wprot;
		next_lost = lost;
		next_gate = gate;
		next_pend_v = pend_v;
		next_pend_data = pend_data;
		next_pend_clk = pend_clk;
		next_pend_mark = pend_mark;
		next_pump_mode = pump_mode;
		next_rd_count = rd_count;
		next_raw_prev = raw_n_s;
		next_ack = req;
		next_dat = 32'h0000_0000;
		if (enc_take) begin
			next_pend_v = 1'b0;
		end
		if (req & ~wb_we_i & (badr == `FDDS_ADR_STATUS)) begin
			next_irq = 1'b0;
		end
		if (req & ~wb_we_i) begin
			unique case (badr)
				`FDDS_ADR_STATUS: next_dat = {24'h00_0000, status};
				`FDDS_ADR_TRACK: next_dat = {24'h00_0000, track};
				`FDDS_ADR_PUMP: next_dat = {30'h0000_0000, pump_mode};
				`FDDS_ADR_RDCNT: next_dat = {16'h0000, rd_count};
				default: next_dat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (badr)
				`FDDS_ADR_CMD: begin
					next_irq = 1'b0;
					if (kind == FDDS_K_STOP) begin
						if ((state == FDDS_S_WRITE) | (state == FDDS_S_SETTLE & is_write)) begin
							next_state = FDDS_S_DRAIN;
						end else if (state != FDDS_S_IDLE & state != FDDS_S_DRAIN) begin
							next_state = FDDS_S_IDLE;
							next_irq = 1'b1;
						end
					end else if (state == FDDS_S_IDLE) begin
						unique case (kind)
							FDDS_K_SEEK: next_irq = 1'b1;
							FDDS_K_RD_SECTOR, FDDS_K_RD_TRACK, FDDS_K_WR_SECTOR, FDDS_K_WR_TRACK: begin
								next_side = wb_dat_i[`FDDS_CMD_SIDE_BIT];
								next_rnf = 1'b0;
								next_wprot = 1'b0;
								next_lost = 1'b0;
								next_is_write = (kind == FDDS_K_WR_SECTOR) | (kind == FDDS_K_WR_TRACK);
								if (!ready_s) begin
									next_irq = 1'b1;
								end else if (next_is_write & ~protect_n_s) begin
									next_wprot = 1'b1;
									next_irq = 1'b1;
								end else begin
									next_state = FDDS_S_SETTLE;
									next_rd_count = 16'h0000;
								end
							end
							default: next_irq = irq;
						endcase
					end
				end
				`FDDS_ADR_TRACK: next_track = wb_dat_i[7:0];
				`FDDS_ADR_ID: begin
					if (wb_dat_i[`FDDS_ID_SIDE_BIT] != side) begin
						next_rnf = 1'b1;
					end
				end
				`FDDS_ADR_WDATA, `FDDS_ADR_WMARK: begin
					next_pend_v = 1'b1;
					next_pend_data = wb_dat_i[7:0];
					next_pend_clk = wb_dat_i[`FDDS_MARK_CLK_LSB+7:`FDDS_MARK_CLK_LSB];
					next_pend_mark = (badr == `FDDS_ADR_WMARK);
				end
				`FDDS_ADR_PUMP: next_pump_mode = wb_dat_i[1:0];
				default: next_pend_v = next_pend_v;
			endcase
		end
		unique case (state)
			FDDS_S_IDLE: next_gate = 1'b0;
			FDDS_S_SETTLE: begin
				if (settled_s) begin
					next_state = is_write ? FDDS_S_WRITE : FDDS_S_READ;
					next_gate = is_write;
				end
			end
			FDDS_S_READ: begin
				if (raw_prev & ~raw_n_s) begin
					next_rd_count = rd_count + 16'h0001;
				end
			end
			FDDS_S_WRITE: next_gate = 1'b1;
			FDDS_S_DRAIN: begin
				if (enc_st == FDDS_E_IDLE) begin
					next_gate = 1'b0;
					next_state = FDDS_S_IDLE;
					next_irq = 1'b1;
				end
			end
			default: next_state = FDDS_S_IDLE;
		endcase
		if (enc_lost) begin
			next_lost = 1'b1;
		end
		next_zone = (next_state != FDDS_S_IDLE) & (next_track >= `FDDS_ZONE_LO) & (next_track <= `FDDS_ZONE_HI);
		next_pump_oe_q = ~test_n_i | (pump_mode == `FDDS_PUMP_UP) | (pump_mode == `FDDS_PUMP_DOWN);
		next_pump_q = ~test_n_i ? raw_n_s : (pump_mode == `FDDS_PUMP_UP);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= FDDS_S_IDLE;
			is_write <= 1'b0;
			side <= 1'b0;
			track <= `FDDS_TRACK_RST;
			irq <= 1'b0;
			record_not_found <= 1'b0;
			wprot <= 1'b0;
			lost <= 1'b0;
			gate <= 1'b0;
			zone <= 1'b0;
			pend_v <= 1'b0;
			pend_data <= 8'h00;
			pend_clk <= 8'h00;
			pend_mark <= 1'b0;
			pump_mode <= `FDDS_PUMP_RST;
			pump_q <= 1'b0;
			pump_oe_q <= 1'b0;
			rd_count <= 16'h0000;
			raw_prev <= 1'b1;
			ack <= 1'b0;
			dat <= 32'h0000_0000;
		end else begin
			state <= next_state;
			is_write <= next_is_write;
			side <= next_side;
			track <= next_track;
			irq <= next_irq;
			record_not_found <= next_rnf;
			wprot <= next_wprot;
			lost <= next_lost;
			gate <= next_gate;
			zone <= next_zone;
			pend_v <= next_pend_v;
			pend_data <= next_pend_data;
			pend_clk <= next_pend_clk;
			pend_mark <= next_pend_mark;
			pump_mode <= next_pump_mode;
			pump_q <= next_pump_q;
			pump_oe_q <= next_pump_oe_q;
			rd_count <= next_rd_count;
			raw_prev <= next_raw_prev;
			ack <= next_ack;
			dat <= next_dat;
		end
	end

	// Halving is done by stretching counts, so the logic never leaves the single clock
	always_comb begin
		cell_len = density_select_n_i ? FM_CELL : MFM_CELL;
		if (!mini_floppy_clock_halve_n_i) begin
			cell_len = {cell_len[9:0], 1'b0};
		end
	end

	always_comb begin
		next_enc_st = enc_st;
		next_cells = cells;
		next_cell_idx = cell_idx;
		next_cell_cnt = cell_cnt;
		next_prev_bit = prev_bit;
		next_wpulse = 1'b0;
		enc_take = 1'b0;
		enc_lost = 1'b0;
		unique case (enc_st)
			FDDS_E_IDLE: begin
				if (enc_go & pend_v) begin
					enc_take = 1'b1;
					next_cells = fdds_cells(pend_data, pend_clk, pend_mark, prev_bit, ~density_select_n_i);
					next_prev_bit = pend_data[0];
					next_cell_idx = 4'h0;
					next_cell_cnt = 11'h000;
					next_enc_st = FDDS_E_RUN;
				end
			end
			FDDS_E_RUN: begin
				next_wpulse = cells[15] & (cell_cnt < PULSE_LEN);
				next_cell_cnt = cell_cnt + 11'h001;
				if (cell_cnt == cell_len - 11'h001) begin
					next_cell_cnt = 11'h000;
					next_cells = {cells[14:0], 1'b0};
					next_cell_idx = cell_idx + 4'h1;
					if (cell_idx == 4'hF) begin
						if (enc_go & pend_v) begin
							enc_take = 1'b1;
							next_cells = fdds_cells(pend_data, pend_clk, pend_mark, prev_bit, ~density_select_n_i);
							next_prev_bit = pend_data[0];
						end else if (enc_go) begin
							// Late data costs a zero byte rather than a gap in the track
							enc_lost = 1'b1;
							next_cells = fdds_cells(8'h00, 8'h00, 1'b0, prev_bit, ~density_select_n_i);
							next_prev_bit = 1'b0;
						end else begin
							next_enc_st = FDDS_E_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enc_st <= FDDS_E_IDLE;
			cells <= 16'h0000;
			cell_idx <= 4'h0;
			cell_cnt <= 11'h000;
			prev_bit <= 1'b0;
			wpulse <= 1'b0;
		end else begin
			enc_st <= next_enc_st;
			cells <= next_cells;
			cell_idx <= next_cell_idx;
			cell_cnt <= next_cell_cnt;
			prev_bit <= next_prev_bit;
			wpulse <= next_wpulse;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;
	assign side_select_out_o = side;
	assign inner_track_zone_o = zone;
	assign write_gate_o = gate;
	assign write_pulse_out_o = wpulse;
	assign head_load_out_o = (state != FDDS_S_IDLE);
	assign irq_out_o = irq;
	assign pump_o = pump_q;
	assign pump_oe_o = pump_oe_q;

endmodule : fdds_side_signals

/* core/fdds_defines.svh */
// Register map, field positions, reset values and timing counts of the drive-side block
`ifndef FDDS_DEFINES_SVH
`define FDDS_DEFINES_SVH

`define FDDS_ADR_CMD 8'h00
`define FDDS_ADR_STATUS 8'h04
`define FDDS_ADR_TRACK 8'h08
`define FDDS_ADR_ID 8'h0C
`define FDDS_ADR_WDATA 8'h10
`define FDDS_ADR_WMARK 8'h14
`define FDDS_ADR_PUMP 8'h18
`define FDDS_ADR_RDCNT 8'h1C

`define FDDS_CMD_KIND_MSB 2
`define FDDS_CMD_SIDE_BIT 3
`define FDDS_ID_SIDE_BIT 0
`define FDDS_MARK_CLK_LSB 8

`define FDDS_ST_BUSY 0
`define FDDS_ST_DRQ 1
`define FDDS_ST_LOST 2
`define FDDS_ST_TRK0 3
`define FDDS_ST_RNF 4
`define FDDS_ST_INDEX 5
`define FDDS_ST_WPROT 6
`define FDDS_ST_NRDY 7

`define FDDS_TRACK_RST 8'h00
`define FDDS_PUMP_RST 2'h0
`define FDDS_PUMP_UP 2'h1
`define FDDS_PUMP_DOWN 2'h2
`define FDDS_ZONE_LO 8'h2C
`define FDDS_ZONE_HI 8'h4C

`define FDDS_CLK_MHZ 250
`define FDDS_FM_HALF_CELL_NS 2000
`define FDDS_MFM_HALF_CELL_NS 1000
`define FDDS_PULSE_NS 250
`define FDDS_FM_CELL_CYC ((`FDDS_FM_HALF_CELL_NS * `FDDS_CLK_MHZ) / 1000)
`define FDDS_MFM_CELL_CYC ((`FDDS_MFM_HALF_CELL_NS * `FDDS_CLK_MHZ) / 1000)
`define FDDS_PULSE_CYC ((`FDDS_PULSE_NS * `FDDS_CLK_MHZ + 999) / 1000)

`endif

/* core/fdds_pkg.sv */
// Types shared by the drive-side block
package fdds_pkg;

	typedef enum logic [2:0] {
		FDDS_S_IDLE = 3'b000,
		FDDS_S_SETTLE = 3'b001,
		FDDS_S_READ = 3'b010,
		FDDS_S_WRITE = 3'b011,
		FDDS_S_DRAIN = 3'b100
	} fdds_state_t;

	typedef enum logic [2:0] {
		FDDS_K_SEEK = 3'b000,
		FDDS_K_RD_SECTOR = 3'b001,
		FDDS_K_WR_SECTOR = 3'b010,
		FDDS_K_RD_TRACK = 3'b011,
		FDDS_K_WR_TRACK = 3'b100,
		FDDS_K_STOP = 3'b101
	} fdds_kind_t;

	typedef enum logic {
		FDDS_E_IDLE = 1'b0,
		FDDS_E_RUN = 1'b1
	} fdds_enc_t;

endpackage : fdds_pkg

/* core/fdds_sync.sv */
// Two-stage synchroniser for the asynchronous drive inputs
`timescale 1ns/10ps
module fdds_sync #(
	parameter int WIDTH = 6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_stage1 = async_i;
		next_sync = stage1;
	end

	// Reset to idle-high keeps active-low drive lines inactive until real samples arrive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= {WIDTH{1'b1}};
			sync_o <= {WIDTH{1'b1}};
		end else begin
			stage1 <= next_stage1;
			sync_o <= next_sync;
		end
	end

endmodule : fdds_sync

/* test/fdds_side_signals_properties.sv */
// Port-level assertions for the drive-side block
`timescale 1ns/10ps
module fdds_side_signals_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic ready_i,
	input wire logic side_select_out_o,
	input wire logic inner_track_zone_o,
	input wire logic write_gate_o,
	input wire logic write_pulse_out_o,
	input wire logic head_load_out_o,
	input wire logic irq_out_o,
	input wire logic pump_oe_o
);
	logic cmd;
	logic rdwr;
	logic cmd_side;
	logic next_cmd_side;
	logic [6:0] pw;
	logic [6:0] next_pw;
	logic [2:0] up;
	logic [2:0] next_up;
	// Only commands taken while idle; the bench always enables byte lane 0
	assign cmd = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (wb_adr_i[7:2] == 6'h00) && !head_load_out_o;
	assign rdwr = (wb_dat_i[2:0] != 3'h0) && (wb_dat_i[2:0] < 3'h5);
	always_comb begin
		next_cmd_side = (cmd && rdwr) ? wb_dat_i[3] : cmd_side;
		next_pw = write_pulse_out_o ? pw + 7'h01 : 7'h00;
		next_up = (up == 3'h7) ? up : up + 3'h1;
		// Synchronisers still hold their reset value just after release
		if (rst_i) begin
			next_up = 3'h0;
		end
	end
	always_ff @(posedge clk_i) begin
		cmd_side <= next_cmd_side;
		pw <= next_pw;
		up <= next_up;
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_quiet_a: assert property (disable iff (1'h0) rst_i |=> !side_select_out_o && !pump_oe_o)
		else $error("side select or pump driven after reset");
	side_follow_a: assert property (cmd && rdwr |-> ##[1:2] side_select_out_o == cmd_side)
		else $error("side select does not follow command");
	side_hold_a: assert property ($changed(side_select_out_o) |-> $past(cmd && rdwr) || $past(cmd && rdwr, 2))
		else $error("side select changed outside command start");
	zone_idle_a: assert property (!head_load_out_o && $past(!head_load_out_o) |-> !inner_track_zone_o)
		else $error("inner zone high while idle");
	gate_first_a: assert property ($rose(write_pulse_out_o) |-> write_gate_o && $past(write_gate_o))
		else $error("write pulse without prior gate");
	pulse_width_a: assert property ($fell(write_pulse_out_o) |-> pw == 7'h3F)
		else $error("write pulse width wrong");
	load_gate_a: assert property (write_gate_o |-> head_load_out_o)
		else $error("writing with head unloaded");
	ready_refuse_a: assert property (cmd && rdwr && !ready_i && $past(!ready_i) && $past(!ready_i, 2) && up == 3'h7
		|=> !head_load_out_o ##[0:1] irq_out_o) else $error("not ready command not refused");
	seek_irq_a: assert property (cmd && wb_dat_i[2:0] == 3'h0 |-> ##[1:2] irq_out_o)
		else $error("seek did not complete");
	cover property (write_gate_o && write_pulse_out_o);
	cover property (inner_track_zone_o && side_select_out_o);
	cover property ($rose(irq_out_o) && !head_load_out_o);
endmodule : fdds_side_signals_checker
bind fdds_side_signals fdds_side_signals_checker i_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.ready_i(ready_i), .side_select_out_o(side_select_out_o), .inner_track_zone_o(inner_track_zone_o),
	.write_gate_o(write_gate_o), .write_pulse_out_o(write_pulse_out_o), .head_load_out_o(head_load_out_o),
	.irq_out_o(irq_out_o), .pump_oe_o(pump_oe_o));

/* test/fdds_drive_model.sv */
// Behavioural floppy drive facing the drive-side block
`timescale 1ns/10ps
module fdds_drive_model #(
	parameter int SETTLE_CYC = 20,
	parameter int INDEX_CYC = 3000,
	parameter int FLUX_CYC = 37
) (
	input wire logic clk_i,
	input wire logic head_load_i,
	input wire logic write_gate_i,
	input wire logic at_track0_i,
	output logic head_settled_o,
	output logic track_zero_n_o,
	output logic index_n_o,
	output logic raw_read_n_o
);
	int settle = 0;
	int rev = 0;
	int flux = 0;
	initial begin
		head_settled_o = 1'h0;
		track_zero_n_o = 1'h1;
		index_n_o = 1'h1;
		raw_read_n_o = 1'h1;
	end
	always @(posedge clk_i) begin
		settle <= head_load_i ? ((settle < SETTLE_CYC) ? settle + 1 : settle) : 0;
		head_settled_o <= head_load_i && (settle >= SETTLE_CYC);
		track_zero_n_o <= !at_track0_i;
		rev <= (rev >= INDEX_CYC - 1) ? 0 : rev + 1;
		index_n_o <= !(rev < 4);
		// low pulse per transition; line idles high as if pulled up
		flux <= (flux >= FLUX_CYC - 1) ? 0 : flux + 1;
		raw_read_n_o <= !(head_load_i && !write_gate_i && flux < 2);
	end
endmodule : fdds_drive_model

/* test/testbench.sv */
// Self-checking bench for the drive-side block
`timescale 1ns/10ps
`include "fdds_defines.svh"
module testbench;
	typedef struct {
		logic we;
		logic [7:0] adr;
		logic [31:0] wd;
		logic [31:0] exp;
	} fdds_row_t;
	fdds_row_t rows [0:5] = '{
		'{1'h1, `FDDS_ADR_TRACK, 32'h2C, 32'h0},
		'{1'h0, `FDDS_ADR_TRACK, 32'h0, 32'h2C},
		'{1'h1, `FDDS_ADR_TRACK, 32'hFFFFFF4C, 32'h0},
		'{1'h0, `FDDS_ADR_TRACK, 32'h0, 32'h4C},
		'{1'h1, 8'h20, 32'h55, 32'h0},
		'{1'h0, 8'h20, 32'h0, 32'h0}};
	logic [7:0] trk [0:3] = '{8'h2B, 8'h2C, 8'h4C, 8'h4D};
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic test_n, ready, prot_n, at_trk0, settled, trk0_n, index_n, raw_n;
	logic side, zone, gate, wpulse, hload, irq, pump, pump_oe, pulse_prev;
	int n_errors = 0;
	int check_count = 0;
	int cyc_count = 0;
	int pulses = 0;
	int t_first = 0;
	int t_second = 0;
	logic halve_n = 1'h1;
	logic density_select_n_n = 1'h1;
	int i, k, v;
	// Straps start at full-rate FM; keeps the halving input high until the halved test
	fdds_side_signals i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mini_floppy_clock_halve_n_i(halve_n), .density_select_n_i(density_select_n_n),
		.test_n_i(test_n), .ready_i(ready), .protect_tab_in_n_i(prot_n), .track_zero_in_n_i(trk0_n),
		.index_n_i(index_n), .raw_read_n_i(raw_n), .head_settled_in_i(settled), .side_select_out_o(side),
		.inner_track_zone_o(zone), .write_gate_o(gate), .write_pulse_out_o(wpulse), .head_load_out_o(hload),
		.irq_out_o(irq), .pump_o(pump), .pump_oe_o(pump_oe));
	fdds_drive_model i_drive (.clk_i(clk_i), .head_load_i(hload), .write_gate_i(gate), .at_track0_i(at_trk0),
		.head_settled_o(settled), .track_zero_n_o(trk0_n), .index_n_o(index_n), .raw_read_n_o(raw_n));
	always #2 clk_i = ~clk_i;
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", w, e, g);
			n_errors++;
		end
	endtask : chk
	// Classic cycle: hold the request until ack is sampled, then drop it
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'h1);
		r = wb_dat_o;
		// Registered slave answers one cycle after the edge that takes the request
		chk("ack_delay", 32'h2, n);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb
	always @(posedge clk_i) begin
		pulse_prev <= wpulse;
		if (wpulse === 1'h1 && pulse_prev === 1'h0) begin
			pulses <= pulses + 1;
			if (pulses == 0) t_first <= cyc_count;
			if (pulses == 1) t_second <= cyc_count;
		end
		cyc_count <= cyc_count + 1;
		// Whole run needs about 17000 cycles
		if (cyc_count == 40000) begin
			n_errors++;
			conclude();
		end
	end
	initial begin
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i = 1'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		test_n = 1'h1;
		ready = 1'h1;
		prot_n = 1'h1;
		at_trk0 = 1'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chk("side", 1'h0, side);
		chk("pump_oe", 1'h0, pump_oe);
		for (i = 0; i < 6; i++) begin
			wb(rows[i].we, rows[i].adr, rows[i].wd, q);
			if (!rows[i].we) chk("reg", rows[i].exp, q);
		end
		for (i = 0; i < 3; i++) begin
			v = (i + 1) % 3;
			wb(1'h1, `FDDS_ADR_PUMP, 32'(v), q);
			@(posedge clk_i);
			chk("pump_oe", v != 0, pump_oe);
			if (v != 0) chk("pump", v == 1, pump);
		end
		test_n <= 1'h0;
		repeat (4) @(posedge clk_i);
		chk("pump_oe_test", 1'h1, pump_oe);
		chk("pump_test", 1'h1, pump);
		test_n <= 1'h1;
		ready <= 1'h0;
		at_trk0 <= 1'h1;
		repeat (4) @(posedge clk_i);
		wb(1'h0, `FDDS_ADR_STATUS, 32'h0, q);
		chk("not_ready", 1'h1, q[`FDDS_ST_NRDY]);
		chk("track0", 1'h1, q[`FDDS_ST_TRK0]);
		for (i = 0; i < 2; i++) begin
			wb(1'h1, `FDDS_ADR_CMD, 32'(i), q);
			repeat (3) @(posedge clk_i);
			chk("irq", 1'h1, irq);
			chk("head_load", 1'h0, hload);
			wb(1'h0, `FDDS_ADR_STATUS, 32'h0, q);
			@(posedge clk_i);
			chk("irq_clear", 1'h0, irq);
		end
		ready <= 1'h1;
		at_trk0 <= 1'h0;
		prot_n <= 1'h0;
		repeat (4) @(posedge clk_i);
		wb(1'h1, `FDDS_ADR_CMD, 32'h2, q);
		repeat (3) @(posedge clk_i);
		chk("irq", 1'h1, irq);
		chk("gate", 1'h0, gate);
		wb(1'h0, `FDDS_ADR_STATUS, 32'h0, q);
		chk("wprot", 1'h1, q[`FDDS_ST_WPROT]);
		prot_n <= 1'h1;
		for (i = 0; i < 4; i++) begin
			wb(1'h1, `FDDS_ADR_TRACK, {24'h0, trk[i]}, q);
			wb(1'h1, `FDDS_ADR_CMD, {28'h0, i[1], 3'h1}, q);
			for (k = 0; k < 100 && settled !== 1'h1; k++) @(posedge clk_i);
			// Long enough in read for at least one flux pulse
			repeat (40) @(posedge clk_i);
			chk("zone", i == 1 || i == 2, zone);
			chk("side", i[1], side);
			wb(1'h1, `FDDS_ADR_ID, {31'h0, i[0]}, q);
			wb(1'h1, `FDDS_ADR_CMD, 32'h5, q);
			repeat (3) @(posedge clk_i);
			chk("side_held", i[1], side);
			wb(1'h0, `FDDS_ADR_STATUS, 32'h0, q);
			chk("rnf", i[0] ^ i[1], q[`FDDS_ST_RNF]);
			wb(1'h0, `FDDS_ADR_RDCNT, 32'h0, q);
			chk("rd_count", 1'h1, q[15:0] != 16'h0);
		end
		wb(1'h1, `FDDS_ADR_TRACK, 32'h30, q);
		wb(1'h1, `FDDS_ADR_WDATA, 32'hA5, q);
		pulses = 0;
		wb(1'h1, `FDDS_ADR_CMD, 32'hA, q);
		for (k = 0; k < 200 && gate !== 1'h1; k++) @(posedge clk_i);
		chk("gate", 1'h1, gate);
		chk("early_pulses", 32'h0, pulses);
		chk("zone", 1'h1, zone);
		chk("side", 1'h1, side);
		chk("head_load", 1'h1, hload);
		repeat (100) @(posedge clk_i);
		wb(1'h1, `FDDS_ADR_CMD, 32'h5, q);
		for (k = 0; k < 9000 && gate !== 1'h0; k++) @(posedge clk_i);
		repeat (300) @(posedge clk_i);
		// One FM byte of 0xA5: eight clock pulses and four data pulses
		chk("pulses", 32'hC, pulses);
		chk("fm_spacing", 32'h1F4, t_second - t_first);
		chk("irq_done", 1'h1, irq);
		// Mid-run reset while side select is high
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chk("side_reset", 1'h0, side);
		// MFM with halved clock: cells stretch to 500 cycles
		halve_n <= 1'h0;
		density_select_n_n <= 1'h0;
		wb(1'h1, `FDDS_ADR_WDATA, 32'hA5, q);
		pulses = 0;
		wb(1'h1, `FDDS_ADR_CMD, 32'h2, q);
		for (k = 0; k < 200 && gate !== 1'h1; k++) @(posedge clk_i);
		repeat (100) @(posedge clk_i);
		wb(1'h1, `FDDS_ADR_CMD, 32'h5, q);
		for (k = 0; k < 9000 && gate !== 1'h0; k++) @(posedge clk_i);
		repeat (300) @(posedge clk_i);
		// 0xA5 in MFM after a zero bit: one clock pulse and four data pulses
		chk("mfm_pulses", 32'h5, pulses);
		chk("mfm_spacing", 32'h7D0, t_second - t_first);
		conclude();
	end
endmodule : testbench
